// File: src/osc_consts.svh
// constants for the oscillator clock source control block
`ifndef OSC_CONSTS_SVH
`define OSC_CONSTS_SVH
// register byte offsets
`define OSC_CFG_OFFSET 32'h0000_0000
`define OSC_STAT_OFFSET 32'h0000_0004
// field positions in the config register
`define OSC_CFG_KEEP_BIT 0
`define OSC_CFG_RCDIS_BIT 1
// field positions in the status register
`define OSC_STAT_XGATE_BIT 0
`define OSC_STAT_RGATE_BIT 1
`define OSC_STAT_STOP_BIT 2
// reset values
`define OSC_CFG_RESET 2'h0
// timing: core clock and nominal rc clock rate
`define OSC_CORE_CLK_HZ 25000000
`define OSC_RC_CLK_HZ 64000
// half period of the rc clock in core cycles, rounded down
`define OSC_RC_HALF_CYCLES (`OSC_CORE_CLK_HZ / (2 * `OSC_RC_CLK_HZ))
`endif

// File: src/osc_pkg.sv
// types shared by the oscillator clock source control block
package osc_pkg;
  typedef enum logic [1:0]
  {
    OSC_RESP_OKAY = 2'b00,
    OSC_RESP_SLVERR = 2'b10
  } osc_resp_type;
endpackage

// File: src/osc_clock_ctrl.sv
// oscillator clock source control: rc clock, gated crystal clock, axi4-lite config
//
// How it works
// [R1] the rc clock starts after reset and keeps running in run and wait modes.
// [R2] the rc clock is a free-running divider of the core clock at about 64 kHz.
// [R3] the stop rc disable bit resets to zero; when set the rc clock stops in stop mode.
// [R4] the crystal clock runs while the crystal enable from the integration unit is high.
// [R5] the integration unit drops the crystal enable when it executes stop.
// [R6] with the stop crystal keep bit set, the crystal clock keeps running in stop mode.
// [R7] wait mode does not touch any of the three clocks.
// [R8] in the break state all three clocks keep running ungated.
// [R9] the pll reference clock is a copy of the crystal clock.
// [R10] the rc clock goes to the integration unit and the watchdog, which never gets the crystal clock.
// [R11] the crystal clock output is the common reference for the downstream consumers.
// [R12] the crystal input is a 32.768 kHz resonator signal taken from the amplifier input pin.
// [R13] the crystal clock and its half-rate version are offered to the system clock selector.
// [R14] gating of either clock changes only while that clock is low, so no pulse is cut short.
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`include "osc_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module osc_clock_ctrl #(
  parameter int RC_HALF = `OSC_RC_HALF_CYCLES
)
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_crystal_amp_input_pin,
  input wire logic i_crystal_osc_enable,
  input wire logic i_stop_mode,
  input wire logic i_wait_mode,
  input wire logic i_break_state,
  output logic o_crystal_amp_output_pin,
  output logic o_internal_rc_clock,
  output logic o_watchdog_clock,
  output logic o_crystal_clock_out,
  output logic o_pll_reference_clock,
  output logic o_crystal_clock_div2,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ****************************************
  // crystal pin synchroniser
  // ****************************************
  logic xtal_meta_reg;
  logic xtal_sync_reg;
  logic xtal_prev_reg;
  logic [1:0] cfg_reg;
  logic rc_src_reg;
  logic [8:0] rc_cnt_reg;
  logic rc_gate_reg;
  logic xtal_gate_reg;
  logic xtal_run;
  logic rc_run;
  logic wr_go;
  logic rd_go;

  // two flops before anything reads the pin
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      xtal_meta_reg <= 1'b0;
      xtal_sync_reg <= 1'b0;
      xtal_prev_reg <= 1'b0;
    end
    else
    begin
      xtal_meta_reg <= i_crystal_amp_input_pin;
      xtal_sync_reg <= xtal_meta_reg; // [R12]
      xtal_prev_reg <= xtal_sync_reg;
    end
  end

  // inverting amplifier output mirrors the synced input
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      o_crystal_amp_output_pin <= 1'b1;
    else
      o_crystal_amp_output_pin <= ~xtal_sync_reg;
  end

  // ****************************************
  // run decisions
  // ****************************************
  // wait mode is deliberately absent from both terms
  assign xtal_run = i_crystal_osc_enable // [R4] [R5] [R7]
    | (i_stop_mode & cfg_reg[`OSC_CFG_KEEP_BIT]) // [R6]
    | i_break_state; // [R8]
  assign rc_run = ~(i_stop_mode & cfg_reg[`OSC_CFG_RCDIS_BIT]) // [R1] [R3]
    | i_break_state; // [R8]

  // ****************************************
  // internal rc clock
  // ****************************************
  // free-running source divider, never stopped so restart is immediate
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      rc_cnt_reg <= 9'h000;
      rc_src_reg <= 1'b0;
    end
    else if (rc_cnt_reg == 9'(RC_HALF - 1))
    begin
      rc_cnt_reg <= 9'h000;
      rc_src_reg <= ~rc_src_reg; // [R2]
    end
    else
      rc_cnt_reg <= rc_cnt_reg + 9'h001;
  end

  // gate moves only while the source is low
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      rc_gate_reg <= 1'b1; // [R1]
    else if (!rc_src_reg)
      rc_gate_reg <= rc_run; // [R14]
  end

  // rc clock to the integration unit and the watchdog
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      o_internal_rc_clock <= 1'b0;
      o_watchdog_clock <= 1'b0;
    end
    else
    begin
      o_internal_rc_clock <= rc_src_reg & rc_gate_reg;
      o_watchdog_clock <= rc_src_reg & rc_gate_reg; // [R10]
    end
  end

  // ****************************************
  // crystal clock
  // ****************************************
  // gate moves only while the synced crystal is low
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      xtal_gate_reg <= 1'b0;
    else if (!xtal_sync_reg)
      xtal_gate_reg <= xtal_run; // [R14]
  end

  // crystal clock, pll reference copy and half-rate copy
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      o_crystal_clock_out <= 1'b0;
      o_pll_reference_clock <= 1'b0;
      o_crystal_clock_div2 <= 1'b0;
    end
    else
    begin
      o_crystal_clock_out <= xtal_sync_reg & xtal_gate_reg; // [R11]
      o_pll_reference_clock <= xtal_sync_reg & xtal_gate_reg; // [R9]
      if (xtal_sync_reg & ~xtal_prev_reg & xtal_gate_reg)
        o_crystal_clock_div2 <= ~o_crystal_clock_div2; // [R13]
    end
  end

  // ****************************************
  // axi4-lite slave
  // ****************************************
  // address and data are taken together; one write and one read at a time
  assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
  assign rd_go = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;

  // write channel: ready pulse, then response held until bready
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= osc_pkg::OSC_RESP_OKAY;
      cfg_reg <= `OSC_CFG_RESET; // [R3]
    end
    else
    begin
      s_axi_awready <= wr_go;
      s_axi_wready <= wr_go;
      if (s_axi_awready)
      begin
        s_axi_bvalid <= 1'b1;
        if (s_axi_awaddr[31:2] == `OSC_CFG_OFFSET >> 2)
        begin
          s_axi_bresp <= osc_pkg::OSC_RESP_OKAY;
          if (s_axi_wstrb[0])
            cfg_reg <= s_axi_wdata[1:0];
        end
        else if (s_axi_awaddr[31:2] == `OSC_STAT_OFFSET >> 2)
          s_axi_bresp <= osc_pkg::OSC_RESP_OKAY; // status is read-only
        else
          s_axi_bresp <= osc_pkg::OSC_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read channel: ready pulse, then data held until rready
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= osc_pkg::OSC_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= rd_go;
      if (s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= osc_pkg::OSC_RESP_OKAY;
        if (s_axi_araddr[31:2] == `OSC_CFG_OFFSET >> 2)
          s_axi_rdata <= {30'h0000_0000, cfg_reg};
        else if (s_axi_araddr[31:2] == `OSC_STAT_OFFSET >> 2)
          s_axi_rdata <= {29'h0000_0000, i_stop_mode, rc_gate_reg, xtal_gate_reg};
        else
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= osc_pkg::OSC_RESP_SLVERR;
        end
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_rc_off_req;
    (i_stop_mode & cfg_reg[`OSC_CFG_RCDIS_BIT] & ~i_break_state) [*3];
  endsequence

  property p_rc_toggle;
    rc_cnt_reg == 9'(RC_HALF - 1) |=> rc_src_reg != $past(rc_src_reg);
  endproperty
  a_rc_toggle: assert property (p_rc_toggle) else $error("rc divider did not toggle"); // [R2]

  property p_rc_stops;
    s_rc_off_req ##1 (i_stop_mode & cfg_reg[`OSC_CFG_RCDIS_BIT] & ~i_break_state) [*1]
      |-> ##[0:400] !rc_gate_reg;
  endproperty
  a_rc_stops: assert property (p_rc_stops) else $error("rc clock not gated in stop"); // [R3]

  property p_rc_glitch;
    $changed(rc_gate_reg) |-> !$past(rc_src_reg);
  endproperty
  a_rc_glitch: assert property (p_rc_glitch) else $error("rc gate moved while high"); // [R14]

  property p_xtal_glitch;
    $changed(xtal_gate_reg) |-> !$past(xtal_sync_reg);
  endproperty
  a_xtal_glitch: assert property (p_xtal_glitch) else $error("crystal gate moved while high"); // [R14]

  property p_xtal_enable;
    (!xtal_sync_reg & !i_crystal_osc_enable & !i_stop_mode & !i_break_state) |=> !xtal_gate_reg;
  endproperty
  a_xtal_enable: assert property (p_xtal_enable) else $error("crystal ran without enable"); // [R4]

  property p_xtal_keep;
    (!xtal_sync_reg & i_stop_mode & cfg_reg[`OSC_CFG_KEEP_BIT]) |=> xtal_gate_reg;
  endproperty
  a_xtal_keep: assert property (p_xtal_keep) else $error("crystal stopped despite keep bit"); // [R6]

  property p_break_run;
    (i_break_state & !xtal_sync_reg & !rc_src_reg) |=> (xtal_gate_reg & rc_gate_reg);
  endproperty
  a_break_run: assert property (p_break_run) else $error("clock gated in break"); // [R8]

  property p_wait_none;
    (i_wait_mode & !i_stop_mode & !rc_src_reg) |=> rc_gate_reg;
  endproperty
  a_wait_none: assert property (p_wait_none) else $error("rc clock gated in wait"); // [R7]

  property p_ref_copy;
    o_pll_reference_clock == o_crystal_clock_out;
  endproperty
  a_ref_copy: assert property (p_ref_copy) else $error("pll reference differs from crystal"); // [R9]

  property p_wd_copy;
    o_watchdog_clock == o_internal_rc_clock;
  endproperty
  a_wd_copy: assert property (p_wd_copy) else $error("watchdog clock not the rc clock"); // [R10]

  property p_wr_resp;
    s_axi_awready |=> s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("no write response after accept");

endmodule
`default_nettype wire

// File: tb/osc_far_model.sv
// far-side model: integration unit mode lines and crystal resonator signal
`timescale 1ns/1ns
`default_nettype none
module osc_far_model #(
  parameter int XTAL_HALF = 5
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_stop_req,
  input wire logic i_break_req,
  output logic o_xtal_pin,
  output logic o_osc_enable,
  output logic o_stop_mode,
  output logic o_break_state
);
  int cnt;
  // resonator stand-in, kept far slower than the core clock so the syncs see every level
  always_ff @(posedge i_clk)
  begin
    cnt <= (i_rst || cnt == XTAL_HALF - 1) ? 0 : cnt + 1;
    if (i_rst)
      o_xtal_pin <= 1'b0;
    else if (cnt == XTAL_HALF - 1)
      o_xtal_pin <= ~o_xtal_pin;
  end
  // stop drops the crystal enable in the same cycle the stop level rises
  always_ff @(posedge i_clk)
  begin
    o_stop_mode <= i_stop_req;
    o_osc_enable <= ~i_stop_req;
    o_break_state <= i_break_req;
  end
endmodule
`default_nettype wire

// File: tb/osc_clock_ctrl_tb.sv
// self-checking bench for the oscillator clock source control block
`include "osc_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module osc_clock_ctrl_tb;
  localparam int RCH = 4;
  localparam int XH = 5;
  localparam int WIN = 80;
  logic clk, rst, stop_req, brk_req, wait_m, xpin, oen, stopm, brk, amp_out, rc, wd, xo, pll, div2;
  logic [31:0] awaddr, wdata, araddr, rdata, rd_v;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, rsp;
  logic [4:0] prev;
  int cnt[5];
  int miscompares = 0;
  int n_tests = 0;
  osc_far_model #(.XTAL_HALF(XH)) u_osc_far_model (.i_clk(clk), .i_rst(rst), .i_stop_req(stop_req),
    .i_break_req(brk_req), .o_xtal_pin(xpin), .o_osc_enable(oen), .o_stop_mode(stopm), .o_break_state(brk));
  osc_clock_ctrl #(.RC_HALF(RCH)) u_osc_clock_ctrl (.i_core_clk(clk), .i_sys_rst(rst),
    .i_crystal_amp_input_pin(xpin), .i_crystal_osc_enable(oen), .i_stop_mode(stopm), .i_wait_mode(wait_m),
    .i_break_state(brk), .o_crystal_amp_output_pin(amp_out), .o_internal_rc_clock(rc), .o_watchdog_clock(wd),
    .o_crystal_clock_out(xo), .o_pll_reference_clock(pll), .o_crystal_clock_div2(div2),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // ****************************************
  // clock, wait noise and edge counters
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // wait mode toggles at random all run long, it must never show on the clocks
  always @(posedge clk)
    wait_m <= 1'($urandom);
  // rising edges of rc, crystal, pll ref, watchdog, div2 in that index order
  always @(posedge clk)
  begin
    foreach (cnt[i])
      if (!prev[i] && {div2, wd, pll, xo, rc}[i])
        cnt[i]++;
    prev <= {div2, wd, pll, xo, rc};
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // each channel is dropped at the edge where its own ready is seen
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    int t;
    t = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      t++;
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1 && t < 100);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int t;
    t = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      t++;
      if (arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1 && t < 100);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  // counts are exact: the window is a whole number of rc, crystal and div2 periods
  task automatic run(input logic s, input logic b, input logic [1:0] k);
    logic ex, er;
    ex = !s || k[0] || b;
    er = !(s && k[1] && !b);
    stop_req <= s;
    brk_req <= b;
    repeat (20) @(posedge clk);
    @(negedge clk);
    foreach (cnt[i])
      cnt[i] = 0;
    repeat (WIN) @(negedge clk);
    chk(cnt[0], er ? WIN / (2 * RCH) : 0);
    chk(cnt[3], cnt[0]);
    chk(cnt[1], ex ? WIN / (2 * XH) : 0);
    chk(cnt[2], cnt[1]);
    chk(cnt[4], ex ? WIN / (4 * XH) : 0);
    @(posedge clk);
    axi_rd(`OSC_STAT_OFFSET, rd_v, rsp);
    chk(rd_v, {29'h0, s, er, ex});
    $display("test stop=%0b break=%0b cfg=%0h done", s, b, k);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    {stop_req, brk_req, wait_m, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
    {awaddr, wdata, araddr} = 96'h0;
    wstrb = 4'hF;
    void'($urandom(55));
    rst = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    axi_rd(`OSC_CFG_OFFSET, rd_v, rsp);
    chk(rd_v, 32'h0);
    for (int k = 0; k < 4; k++)
    begin
      axi_wr(`OSC_CFG_OFFSET, {30'($urandom), 2'(k)}, rsp);
      chk(rsp, osc_pkg::OSC_RESP_OKAY);
      axi_rd(`OSC_CFG_OFFSET, rd_v, rsp);
      chk(rd_v, 32'(k));
      run(1'b0, 1'b0, 2'(k));
      run(1'b1, 1'b0, 2'(k));
      run(1'b1, 1'b1, 2'(k));
    end
    axi_wr(32'h100 + 4 * ($urandom % 60), 32'hFFFF_FFFF, rsp);
    chk(rsp, osc_pkg::OSC_RESP_SLVERR);
    axi_rd(32'h200, rd_v, rsp);
    chk({rd_v, 30'h0, rsp}, {32'h0, 30'h0, osc_pkg::OSC_RESP_SLVERR});
    $display("test unmapped access done");
    summarize();
  end
  // watchdog, well beyond the little over a thousand cycles the sequence needs
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    summarize();
  end
endmodule
`default_nettype wire
